/* File: sdrif_pkg.sv */
package sdrif_pkg;

   // ---------------------------------------------------------------
   // Pin widths
   // ---------------------------------------------------------------
   localparam int ADDR_W    = 14;
   localparam int BANK_W    = 3;
   localparam int LANES     = 2;
   localparam int LANE_W    = 8;
   localparam int DQ_W      = LANES * LANE_W;
   localparam int MEM_DEPTH = 16;
   localparam int BURST_LEN = 4;

   // ---------------------------------------------------------------
   // Register port map (byte offsets)
   // ---------------------------------------------------------------
   localparam int          REG_AW     = 5;
   localparam int          REG_DW     = 16;
   localparam logic [4:0]  REG_CTRL   = 5'h00;
   localparam logic [4:0]  REG_MODE   = 5'h04;
   localparam logic [4:0]  REG_EXT1   = 5'h08;
   localparam logic [4:0]  REG_EXT2   = 5'h0C;
   localparam logic [4:0]  REG_EXT3   = 5'h10;
   localparam logic [4:0]  REG_BANKS  = 5'h14;
   localparam logic [4:0]  REG_STATUS = 5'h18;
   localparam logic [4:0]  REG_DROPS  = 5'h1C;
   localparam logic [15:0] CTRL_RESET = 16'h0001;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam int          CTRL_WORD_WIDE_BIT = 0;

   // ---------------------------------------------------------------
   // Field positions on the address pins
   // ---------------------------------------------------------------
   localparam int SINGLE_ENDED_BIT  = 10;
   localparam int READ_STROBE_BIT   = 11;
   localparam int PRECHARGE_ALL_BIT = 10;
   localparam int AUTO_PRECHARGE_BIT = 10;
   localparam logic [1:0] SEL_BASE = 2'h0;
   localparam logic [1:0] SEL_EXT1 = 2'h1;
   localparam logic [1:0] SEL_EXT2 = 2'h2;
   localparam logic [1:0] SEL_EXT3 = 2'h3;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int READ_LAT_NS   = 24;
   localparam int READ_LAT_CYC  = (READ_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Command code is {row strobe, column strobe, write enable}, all low active
   typedef enum logic [2:0] {
      CMD_LOAD      = 3'h0,
      CMD_REFRESH   = 3'h1,
      CMD_PRECHARGE = 3'h2,
      CMD_ACTIVATE  = 3'h3,
      CMD_WRITE     = 3'h4,
      CMD_READ      = 3'h5,
      CMD_TERMINATE = 3'h6,
      CMD_NOP       = 3'h7
   } sdrif_cmd_e;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_WRITE   = 4'b0010,
      ST_RD_WAIT = 4'b0100,
      ST_READ    = 4'b1000
   } sdrif_state_e;

   typedef struct packed {
      logic              csN;
      logic              rasN;
      logic              casN;
      logic              weN;
      logic [BANK_W-1:0] bankSelect;
      logic [ADDR_W-1:0] addr;
   } sdrif_cmd_s;

   typedef struct packed {
      logic [DQ_W-1:0]  dq;
      logic [LANES-1:0] strobe;
      logic [LANES-1:0] writeMask;
   } sdrif_data_s;

endpackage : sdrif_pkg

/* File: sdrif_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module sdrif_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,   // Core clock
   input  wire logic         rstn,  // Synchronous reset, low active
   input  wire logic [W-1:0] d,     // Asynchronous pin levels
   output logic      [W-1:0] q      // Levels safe for core logic
);

   logic [W-1:0] meta_q;

   // ---------------------------------------------------------------
   // Two-stage synchroniser
   // ---------------------------------------------------------------
   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : sdrif_sync

`default_nettype wire

/* File: sdrif_dev.sv */
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module sdrif_dev
   import sdrif_pkg::*;
#(
   parameter int DEPTH   = sdrif_pkg::MEM_DEPTH,
   parameter int BURST   = sdrif_pkg::BURST_LEN,
   parameter int RD_LAT  = sdrif_pkg::READ_LAT_CYC
) (
   input  wire logic                          clk,            // Core clock, 125 MHz
   input  wire logic                          rstn,           // Synchronous reset, low active
   input  wire logic [sdrif_pkg::REG_AW-1:0]  regAddr,        // Register address
   input  wire logic [sdrif_pkg::REG_DW-1:0]  regWrData,      // Register write data
   input  wire logic                          regWr,          // Register write strobe
   input  wire logic                          regRd,          // Register read strobe
   output logic      [sdrif_pkg::REG_DW-1:0]  regRdData,      // Read data, cycle after strobe
   input  wire sdrif_pkg::sdrif_cmd_s         cmdPins,        // Command and address pins
   input  wire sdrif_pkg::sdrif_data_s        dataPins,       // Data, strobe and mask pins in
   output logic      [sdrif_pkg::DQ_W-1:0]    dqOut,          // Read data to pins
   output logic      [sdrif_pkg::LANES-1:0]   dqOe,           // Data drive enable per byte
   output logic      [sdrif_pkg::LANES-1:0]   strobeOut,      // True strobe per byte
   output logic      [sdrif_pkg::LANES-1:0]   strobeNOut,     // Complementary strobe
   output logic      [sdrif_pkg::LANES-1:0]   strobeOe,       // True strobe drive enable
   output logic      [sdrif_pkg::LANES-1:0]   strobeNOe,      // Complementary drive enable
   output logic                               readStrobeOut,  // Read strobe on mask pin
   output logic                               readStrobeNOut, // Its complement
   output logic                               readStrobeOe,   // Read strobe drive enable
   output logic                               readStrobeNOe   // Complement drive enable
);
   import sdrif_pkg::*;

   localparam int IDX_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(BURST + 1);
   localparam int LAT_W = $clog2(RD_LAT + 1);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   sdrif_cmd_s  cmdS;
   sdrif_data_s dataS;
   logic [LANES-1:0] strobeP_q;

   sdrif_sync #(.W($bits(sdrif_cmd_s))) u_cmd_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (cmdPins),
      .q    (cmdS)
   );

   sdrif_sync #(.W($bits(sdrif_data_s))) u_data_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (dataPins),
      .q    (dataS)
   );

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   function automatic sdrif_cmd_e decodeCmd(input sdrif_cmd_s c);
      if (c.csN) begin
         decodeCmd = CMD_NOP;
      end else begin
         decodeCmd = sdrif_cmd_e'({c.rasN, c.casN, c.weN});
      end
   endfunction : decodeCmd

   sdrif_cmd_e cmd;
   assign cmd = decodeCmd(cmdS);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [REG_DW-1:0]  ctrl_q;
   logic [ADDR_W-1:0]  mode_q;
   logic [ADDR_W-1:0]  ext1_q;
   logic [ADDR_W-1:0]  ext2_q;
   logic [ADDR_W-1:0]  ext3_q;
   logic [7:0]         bankOpen_q;
   logic [REG_DW-1:0]  drops_q;
   sdrif_state_e       state_q;
   logic               wordWide;
   logic               singleEnded;
   logic               readStrobeMode;
   logic               maskActive;

   assign wordWide       = ctrl_q[CTRL_WORD_WIDE_BIT];
   assign singleEnded    = ext1_q[SINGLE_ENDED_BIT];
   assign readStrobeMode = !wordWide && ext1_q[READ_STROBE_BIT];
   assign maskActive     = !readStrobeMode;

   // Software owns the width strap; everything else is read-only
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_q <= CTRL_RESET;
      end else if (regWr && regAddr == REG_CTRL) begin
         ctrl_q <= regWrData;
      end
   end

   // Read port answers one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk) begin
      if (!rstn) begin
         regRdData <= '0;
      end else if (regRd) begin
         case (regAddr)
            REG_CTRL:   regRdData <= ctrl_q;
            REG_MODE:   regRdData <= REG_DW'(mode_q);
            REG_EXT1:   regRdData <= REG_DW'(ext1_q);
            REG_EXT2:   regRdData <= REG_DW'(ext2_q);
            REG_EXT3:   regRdData <= REG_DW'(ext3_q);
            REG_BANKS:  regRdData <= REG_DW'(bankOpen_q);
            REG_STATUS: regRdData <= REG_DW'(state_q);
            REG_DROPS:  regRdData <= drops_q;
            default:    regRdData <= '0;
         endcase
      end else begin
         regRdData <= '0;
      end
   end

   // Mode register load: bank select picks target, address is op-code
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_q <= ADDR_W'(MODE_RESET);
         ext1_q <= ADDR_W'(MODE_RESET);
         ext2_q <= ADDR_W'(MODE_RESET);
         ext3_q <= ADDR_W'(MODE_RESET);
      end else if (cmd == CMD_LOAD && state_q == ST_IDLE) begin
         case (cmdS.bankSelect[1:0])
            SEL_BASE: mode_q <= cmdS.addr;
            SEL_EXT1: ext1_q <= cmdS.addr;
            SEL_EXT2: ext2_q <= cmdS.addr;
            SEL_EXT3: ext3_q <= cmdS.addr;
            default:  mode_q <= mode_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Bank state
   // ---------------------------------------------------------------
   // Auto-precharge closes the bank at command time; real row timing
   // is outside this block
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bankOpen_q <= '0;
      end else begin
         case (cmd)
            CMD_ACTIVATE: bankOpen_q[cmdS.bankSelect] <= 1'b1;
            CMD_PRECHARGE: begin
               if (cmdS.addr[PRECHARGE_ALL_BIT]) begin
                  bankOpen_q <= '0;
               end else begin
                  bankOpen_q[cmdS.bankSelect] <= 1'b0;
               end
            end
            CMD_READ, CMD_WRITE: begin
               if (cmdS.addr[AUTO_PRECHARGE_BIT]) begin
                  bankOpen_q[cmdS.bankSelect] <= 1'b0;
               end
            end
            default: bankOpen_q <= bankOpen_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Burst sequencer
   // ---------------------------------------------------------------
   logic [IDX_W-1:0]  colBase_q;
   logic [LAT_W-1:0]  latCnt_q;
   logic [CNT_W-1:0]  rdBeat_q;
   logic [LANES-1:0]  laneDone;
   logic [LANES-1:0]  laneUsed;
   logic [LANES-1:0]  dropBeat;

   assign laneUsed = {wordWide, 1'b1};

   // Column taken with the command; bank only gates acceptance
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q   <= ST_IDLE;
         colBase_q <= '0;
         latCnt_q  <= '0;
         rdBeat_q  <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cmd == CMD_WRITE && bankOpen_q[cmdS.bankSelect]) begin
                  colBase_q <= cmdS.addr[IDX_W-1:0];
                  state_q   <= ST_WRITE;
               end else if (cmd == CMD_READ && bankOpen_q[cmdS.bankSelect]) begin
                  colBase_q <= cmdS.addr[IDX_W-1:0];
                  latCnt_q  <= '0;
                  state_q   <= ST_RD_WAIT;
               end
            end
            ST_WRITE: begin
               if ((laneDone & laneUsed) == laneUsed) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_RD_WAIT: begin
               if (latCnt_q == LAT_W'(RD_LAT - 1)) begin
                  rdBeat_q <= '0;
                  state_q  <= ST_READ;
               end else begin
                  latCnt_q <= latCnt_q + 1'b1;
               end
            end
            ST_READ: begin
               if (rdBeat_q == CNT_W'(BURST - 1)) begin
                  state_q <= ST_IDLE;
               end
               rdBeat_q <= rdBeat_q + 1'b1;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Write capture, one lane per byte strobe
   // ---------------------------------------------------------------
   logic [LANE_W-1:0] mem_q [LANES][DEPTH];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         strobeP_q <= '0;
      end else begin
         strobeP_q <= dataS.strobe;
      end
   end

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [CNT_W-1:0] beat_q;
         logic             strobeEdge;

         // Both edges of the strobe carry a beat
         assign strobeEdge  = strobeP_q[g] ^ dataS.strobe[g];
         assign laneDone[g] = (beat_q == CNT_W'(BURST));
         assign dropBeat[g] = state_q == ST_WRITE && !laneDone[g] && strobeEdge
                              && laneUsed[g] && maskActive && dataS.writeMask[g];

         always_ff @(posedge clk) begin
            if (!rstn) begin
               beat_q <= '0;
            end else if (state_q != ST_WRITE) begin
               beat_q <= '0;
            end else if (strobeEdge && !laneDone[g]) begin
               beat_q <= beat_q + 1'b1;
            end
         end

         // Storage has no reset; contents are undefined until written
         always_ff @(posedge clk) begin
            if (state_q == ST_WRITE && strobeEdge && !laneDone[g] && laneUsed[g]) begin
               if (!(maskActive && dataS.writeMask[g])) begin
                  mem_q[g][colBase_q + IDX_W'(beat_q)] <= dataS.dq[g*LANE_W +: LANE_W];
               end
            end
         end
      end
   endgenerate

   // Count of discarded beats, visible to software
   always_ff @(posedge clk) begin
      if (!rstn) begin
         drops_q <= '0;
      end else begin
         drops_q <= drops_q + REG_DW'(dropBeat[0]) + REG_DW'(dropBeat[1]);
      end
   end

   // ---------------------------------------------------------------
   // Read drive
   // ---------------------------------------------------------------
   // Data and strobe change on the same edge so the strobe stays
   // edge-aligned; the controller must shift it into the data eye.
   // Reset and idle share one branch so the pins release alike
   always_ff @(posedge clk) begin
      if (rstn && state_q == ST_READ) begin
         for (int l = 0; l < LANES; l++) begin
            dqOut[l*LANE_W +: LANE_W] <= mem_q[l][colBase_q + IDX_W'(rdBeat_q)];
         end
         dqOe           <= laneUsed;
         strobeOut      <= laneUsed & ~strobeOut;
         strobeNOut     <= ~(laneUsed & ~strobeOut);
         strobeOe       <= laneUsed;
         strobeNOe      <= singleEnded ? '0 : laneUsed;
         readStrobeOut  <= readStrobeMode & ~readStrobeOut;
         readStrobeNOut <= ~(readStrobeMode & ~readStrobeOut);
         readStrobeOe   <= readStrobeMode;
         readStrobeNOe  <= readStrobeMode && !singleEnded;
      end else begin
         dqOut          <= '0;
         dqOe           <= '0;
         strobeOut      <= '0;
         strobeNOut     <= '1;
         strobeOe       <= '0;
         strobeNOe      <= '0;
         readStrobeOut  <= 1'b0;
         readStrobeNOut <= 1'b1;
         readStrobeOe   <= 1'b0;
         readStrobeNOe  <= 1'b0;
      end
   end

endmodule : sdrif_dev

`default_nettype wire

/* File: sdrif_dev_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module sdrif_dev_properties #(
   parameter int BURST = 4
) (
   input wire logic                         clk,            // Core clock
   input wire logic                         rstn,           // Sync reset, low active
   input wire logic [sdrif_pkg::REG_AW-1:0] regAddr,        // Register address
   input wire logic                         regRd,          // Register read strobe
   input wire logic [sdrif_pkg::REG_DW-1:0] regRdData,      // Register read data
   input wire logic [sdrif_pkg::LANES-1:0]  dqOe,           // Data drive enables
   input wire logic [sdrif_pkg::LANES-1:0]  strobeOut,      // True strobes
   input wire logic [sdrif_pkg::LANES-1:0]  strobeNOut,     // Complement strobes
   input wire logic [sdrif_pkg::LANES-1:0]  strobeOe,       // True strobe enables
   input wire logic [sdrif_pkg::LANES-1:0]  strobeNOe,      // Complement enables
   input wire logic                         readStrobeOut,  // Read strobe on mask pin
   input wire logic                         readStrobeNOut, // Its complement
   input wire logic                         readStrobeOe,   // Read strobe enable
   input wire logic                         readStrobeNOe   // Complement enable
);
   import sdrif_pkg::*;

   // ------------------------------------------------------------
   // Pin relations during read bursts, and register read data
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   AST_COMP_PAIR: assert property (((strobeNOut ^ strobeOut) & strobeNOe) == strobeNOe)
      else $error("complement strobe not inverse of true strobe");
   AST_COMP_ALL: assert property (strobeNOe != '0 |-> strobeNOe == strobeOe)
      else $error("complement strobes not enabled together");
   AST_READ_DATA_STROBE_COMP: assert property (readStrobeNOe |-> readStrobeNOut != readStrobeOut && strobeNOe[0])
      else $error("read strobe complement wrong");
   AST_OE_LANES: assert property (dqOe == strobeOe)
      else $error("data and strobe enables differ per lane");
   // A stalled strobe would lose a beat at the controller
   AST_STB_TOGGLE: assert property (strobeOe[0] && $past(strobeOe[0]) |-> strobeOut[0] != $past(strobeOut[0]))
      else $error("read strobe did not toggle per beat");
   AST_BURST_LEN: assert property ($fell(dqOe[0]) |-> $past(dqOe[0], BURST) && !$past(dqOe[0], BURST + 1))
      else $error("read burst length wrong");
   AST_READ_DATA_STROBE_LANE: assert property (readStrobeOe |-> dqOe == 2'b01)
      else $error("read strobe outside byte-wide read");
   AST_READ_DATA_STROBE_EDGE: assert property (readStrobeOe |-> readStrobeOut == strobeOut[0])
      else $error("read strobe not aligned with lane strobe");
   AST_RD_IDLE: assert property (!regRd |=> regRdData == '0)
      else $error("read data outside answer cycle");
   AST_UNMAPPED: assert property (regRd && regAddr[1:0] != 2'h0 |=> regRdData == '0)
      else $error("unmapped read not zero");
endmodule : sdrif_dev_properties

bind sdrif_dev sdrif_dev_properties #(.BURST(BURST)) sdrif_dev_properties_inst (.clk, .rstn,
   .regAddr, .regRd, .regRdData, .dqOe, .strobeOut, .strobeNOut, .strobeOe, .strobeNOe,
   .readStrobeOut, .readStrobeNOut, .readStrobeOe, .readStrobeNOe);

`default_nettype wire

/* File: sdrif_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sdrif_ctl_model (
   input  wire logic              clk,     // Core clock
   output var sdrif_pkg::sdrif_cmd_s  cmdPins, // Command pins to device
   output var sdrif_pkg::sdrif_data_s ctlData  // Write data, strobe, mask
);
   import sdrif_pkg::*;

   // ------------------------------------------------------------
   // Controller side of the pins
   // ------------------------------------------------------------
   // Deselected at time zero so no stray command is seen
   initial begin
      cmdPins = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0};
      ctlData = '0;
   end

   // One command cycle, then a flipped bus so a stale value is never reused
   task automatic cmd(input sdrif_cmd_e c, input logic [2:0] b, input logic [13:0] a);
      @(posedge clk);
      cmdPins <= '{1'b0, c[2], c[1], c[0], b, a};
      @(posedge clk);
      cmdPins <= '{1'b1, 1'b1, 1'b1, 1'b1, ~b, ~a};
      repeat (3) @(posedge clk);
   endtask : cmd

   // Four beats, one strobe edge and one mask value each
   task automatic burst(input logic [63:0] d, input logic [7:0] m);
      int i;
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         ctlData.dq        <= d[16*i +: 16];
         ctlData.writeMask <= m[2*i +: 2];
         ctlData.strobe    <= ~ctlData.strobe;
      end
      @(posedge clk);
      ctlData.dq        <= ~d[63:48];
      ctlData.writeMask <= ~m[7:6];
      repeat (3) @(posedge clk);
   endtask : burst
endmodule : sdrif_ctl_model

`default_nettype wire

/* File: sdrif_dev_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sdrif_dev_tb;
   import sdrif_pkg::*;

   logic              clk, rstn, regWr, regRd, rsSeen;
   logic              readStrobeOut, readStrobeNOut, readStrobeOe, readStrobeNOe;
   logic [REG_AW-1:0] regAddr;
   logic [REG_DW-1:0] regWrData, regRdData;
   logic [DQ_W-1:0]   dqOut, laneMask;
   logic [DQ_W-1:0]   capWord [4];
   logic [LANES-1:0]  dqOe, strobeOut, strobeNOut, strobeOe, strobeNOe, nSeen;
   sdrif_cmd_s        cmdPins;
   sdrif_data_s       ctlData, dataPins;
   int                errorCnt, samplesChecked, s;

   // ------------------------------------------------------------
   // Clock, wire resolution and instances
   // ------------------------------------------------------------
   initial clk = 1'b0;
   always #4 clk = ~clk;

   // Shared pins show whoever has the drive enable
   assign laneMask = {{LANE_W{dqOe[1]}}, {LANE_W{dqOe[0]}}};
   assign dataPins = {(dqOut & laneMask) | (ctlData.dq & ~laneMask),
                      (strobeOut & strobeOe) | (ctlData.strobe & ~strobeOe),
                      ctlData.writeMask[1],
                      readStrobeOe ? readStrobeOut : ctlData.writeMask[0]};

   sdrif_ctl_model ctl (.clk(clk), .cmdPins(cmdPins), .ctlData(ctlData));
   sdrif_dev sdrif_dev_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cmdPins(cmdPins),
      .dataPins(dataPins), .dqOut(dqOut), .dqOe(dqOe), .strobeOut(strobeOut),
      .strobeNOut(strobeNOut), .strobeOe(strobeOe), .strobeNOe(strobeNOe),
      .readStrobeOut(readStrobeOut), .readStrobeNOut(readStrobeNOut),
      .readStrobeOe(readStrobeOe), .readStrobeNOe(readStrobeNOe));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic close_out();
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errorCnt++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWr     <= 1'b0;
   endtask : wr

   // Answer stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd   <= 1'b0;
      #1 chk(nm, e, regRdData);
   endtask : rd

   // Read at column 4; oe of zero means the read must be refused
   task automatic rdBurst(input logic [2:0] b, input logic [1:0] oe);
      int k;
      ctl.cmd(CMD_READ, b, 14'h0004);
      for (k = 0; k < 20 && dqOe === 2'b00; k++) @(posedge clk) #1;
      chk("read lanes", 16'(oe), 16'(dqOe));
      if (dqOe !== oe) close_out();
      rsSeen = readStrobeOe;
      nSeen  = strobeNOe;
      for (k = 0; k < 4; k++) begin
         capWord[k] = dqOut;
         @(posedge clk) #1;
      end
   endtask : rdBurst

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      regWr     = 1'b0;
      regRd     = 1'b0;
      regAddr   = '0;
      regWrData = '0;
      rstn      = 1'b0;
      errorCnt  = 0;
      samplesChecked = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(REG_CTRL, CTRL_RESET, "ctrl reset");
      rd(REG_MODE, MODE_RESET, "mode reset");
      rd(5'h02, 16'h0000, "unmapped");
      wr(REG_MODE, 16'h1234);
      rd(REG_MODE, 16'h0000, "mode not writable");
      // Every register select of the load command
      for (s = 0; s < 4; s++) begin
         ctl.cmd(CMD_LOAD, 3'(s), 14'h0120 + 14'(s));
         rd(REG_MODE + 5'(4 * s), 16'h0120 + 16'(s), "mode load");
      end
      ctl.cmd(CMD_ACTIVATE, 3'h2, 14'h0011);
      ctl.cmd(CMD_ACTIVATE, 3'h5, 14'h0022);
      rd(REG_BANKS, 16'h0024, "banks open");
      ctl.cmd(CMD_PRECHARGE, 3'h2, 14'h0000);
      rd(REG_BANKS, 16'h0020, "one closed");
      ctl.cmd(CMD_PRECHARGE, 3'h0, 14'h0400);
      rd(REG_BANKS, 16'h0000, "all closed");
      rdBurst(3'h5, 2'b00);
      ctl.cmd(CMD_ACTIVATE, 3'h5, 14'h0022);
      // Plain write, then a write with one byte masked
      ctl.cmd(CMD_WRITE, 3'h5, 14'h0004);
      ctl.burst(64'h4444_3333_2222_1111, 8'h00);
      ctl.cmd(CMD_WRITE, 3'h5, 14'h0004);
      ctl.burst(64'hDDDD_CCCC_BBBB_AAAA, 8'h04);
      rd(REG_DROPS, 16'h0001, "dropped beats");
      rdBurst(3'h5, 2'b11);
      chk("beat0", 16'hAAAA, capWord[0]);
      chk("beat1", 16'hBB22, capWord[1]);
      chk("beat2", 16'hCCCC, capWord[2]);
      chk("beat3", 16'hDDDD, capWord[3]);
      chk("differential", 16'h0003, 16'(nSeen));
      ctl.cmd(CMD_WRITE, 3'h5, 14'h0404);
      ctl.burst(64'hDDDD_CCCC_BB22_AAAA, 8'h00);
      rd(REG_BANKS, 16'h0000, "auto precharge");
      // Byte-wide, single-ended, read strobe on the mask pin
      wr(REG_CTRL, 16'h0000);
      rd(REG_CTRL, 16'h0000, "ctrl rw");
      ctl.cmd(CMD_LOAD, 3'(SEL_EXT1), 14'h0C00);
      ctl.cmd(CMD_ACTIVATE, 3'h5, 14'h0022);
      ctl.cmd(CMD_WRITE, 3'h5, 14'h0004);
      ctl.burst(64'h0077_0066_0055_0044, 8'hFF);
      rd(REG_DROPS, 16'h0001, "masks ignored");
      rdBurst(3'h5, 2'b01);
      chk("read strobe", 16'h0001, 16'(rsSeen));
      chk("single ended", 16'h0000, 16'(nSeen));
      chk("byte beat1", 16'h0055, 16'h00FF & capWord[1]);
      // Byte-wide read strobe with complements turned back on
      ctl.cmd(CMD_LOAD, 3'(SEL_EXT1), 14'h0800);
      rdBurst(3'h5, 2'b01);
      chk("diff read strobe", 16'h0001, 16'(rsSeen));
      chk("diff byte lane", 16'h0001, 16'(nSeen));
      chk("byte beat2", 16'h0066, 16'h00FF & capWord[2]);
      close_out();
   end
endmodule : sdrif_dev_tb

`default_nettype wire
